/* File: include/sdr_pkg.sv */
// Shared constants and types for the synchronous DRAM device model
package sdr_pkg;
  localparam int BANK_W = 2;
  localparam int ROW_W = 12;
  localparam int COL_W = 8;
  localparam int DATA_W = 16;
  localparam int MASK_W = DATA_W / 8;
  localparam int MODE_W = 12;
  localparam int ADDR_W = BANK_W + ROW_W + COL_W;
  localparam int NUM_BANKS = 4;
  localparam int NUM_STAGES = 2;

  // Mode word field positions
  localparam int BL_LSB = 0;
  localparam int BL_MSB = 2;
  localparam int ORDER_BIT = 3;
  localparam int LAT_LSB = 4;
  localparam int LAT_MSB = 6;
  localparam int OPM_LSB = 7;
  localparam int OPM_MSB = 8;
  localparam int WBM_BIT = 9;
  // Address bit that selects auto precharge or all banks
  localparam int AP_BIT = 10;

  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] LAT_2 = 3'h2;
  localparam logic [2:0] LAT_3 = 3'h3;
  localparam logic [1:0] OPM_NORMAL = 2'h0;
  localparam logic [8:0] LEN_1 = 9'h001;
  localparam logic [8:0] LEN_2 = 9'h002;
  localparam logic [8:0] LEN_4 = 9'h004;
  localparam logic [8:0] LEN_8 = 9'h008;
  localparam logic [8:0] LEN_PAGE = 9'h100;
  // Power-up contents are undefined; this value is arbitrary
  localparam logic [MODE_W-1:0] MODE_RESET = 12'h000;
  localparam logic [MASK_W-1:0] MASK_ALL = 2'h3;
  localparam logic [MASK_W-1:0] MASK_NONE = 2'h0;

  // Codes are {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    CMD_LOAD_MODE = 4'h0,
    CMD_REFRESH = 4'h1,
    CMD_PRECHARGE = 4'h2,
    CMD_ACTIVE = 4'h3,
    CMD_WRITE = 4'h4,
    CMD_READ = 4'h5,
    CMD_TERMINATE = 4'h6,
    CMD_NOP = 4'h7,
    CMD_INHIBIT = 4'h8
  } cmd_type;

  typedef enum logic [1:0] {
    BST_IDLE = 2'h0,
    BST_READ = 2'h1,
    BST_WRITE = 2'h2
  } burst_state_type;
endpackage

/* File: hw/sdr_cell_array.sv */
// Cell array with byte-lane writes and a registered read port
`timescale 1ns/100ps
`default_nettype none
module sdr_cell_array #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [DATA_W/8-1:0] wr_be,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] cells [2**ADDR_W];

  // Cells are not reset; contents are unknown until written
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      for (int i = 0; i < DATA_W / 8; i++) begin
        if (wr_be[i]) begin
          cells[wr_addr][i*8 +: 8] <= wr_data[i*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= cells[rd_addr];
    end
  end
endmodule
`default_nettype wire

/* File: hw/sdr_device.sv */
// Synchronous DRAM device: command decode, bursts, latency, masks
//
// Notes on behaviour
// - Column commands may come every cycle
// - Clock gate low suspends one cycle later
// - Clock gate high resumes one cycle later
// - Write mask applies to same-edge data
// - Read mask floats output two cycles later
// - First write word taken with the command
// - Precharge of the burst bank or all banks floats read output after latency
// - Activate picks bank and row; column later
// - Four banks, 4096 rows, 256 16-bit columns
// - Mode loads only with all banks idle
// - Mode word holds length, order, latency, modes
// - Lengths 1,2,4,8; full page sequential only
// - Burst wraps inside aligned length block
// - Sequential order adds index modulo length
// - Interleaved order XORs index into start
// - Read data valid latency edges after command
// - Only the normal operating mode is accepted
// - Write-burst bit makes writes single location
`timescale 1ns/100ps
`default_nettype none
module sdr_device (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [sdr_pkg::ROW_W-1:0] addr,
  input wire logic [sdr_pkg::MASK_W-1:0] dqm,
  input wire logic [sdr_pkg::DATA_W-1:0] dq_in,
  output logic [sdr_pkg::DATA_W-1:0] dq_out,
  output logic [sdr_pkg::MASK_W-1:0] dq_oe_n
);
  typedef struct packed {
    logic [sdr_pkg::MODE_W-1:0] mode;
    logic cke_q;
    logic [sdr_pkg::MASK_W-1:0] dqm_q;
    logic [sdr_pkg::NUM_BANKS-1:0] bank_open;
    logic [sdr_pkg::NUM_BANKS-1:0][sdr_pkg::ROW_W-1:0] open_row;
    sdr_pkg::burst_state_type bst;
    logic [sdr_pkg::BANK_W-1:0] bst_bank;
    logic [sdr_pkg::COL_W-1:0] bst_start;
    logic [sdr_pkg::COL_W-1:0] bst_idx;
    logic [8:0] bst_left;
    logic bst_ap;
    logic [sdr_pkg::NUM_STAGES-1:0] stg_valid;
    logic [sdr_pkg::NUM_STAGES-1:0][sdr_pkg::ADDR_W-1:0] stg_addr;
    logic [sdr_pkg::MASK_W-1:0] oe_n;
  } state_type;

  state_type st;
  state_type nx;
  sdr_pkg::cmd_type cmd;
  logic [sdr_pkg::BANK_W-1:0] bank;
  logic [8:0] blen;
  logic [8:0] new_len;
  logic full_page;
  logic order;
  logic lat3;
  logic pre_hit;
  logic iss_valid;
  logic iss_wr;
  logic [sdr_pkg::ADDR_W-1:0] iss_addr;
  logic rd_en;
  logic [sdr_pkg::ADDR_W-1:0] rd_addr;

  function automatic sdr_pkg::cmd_type decode(input logic [3:0] pins);
    if (pins[3]) begin
      decode = sdr_pkg::CMD_INHIBIT;
    end else begin
      decode = sdr_pkg::cmd_type'(pins);
    end
  endfunction

  function automatic logic [8:0] burst_len(input logic [2:0] code);
    case (code)
      sdr_pkg::BL_1: burst_len = sdr_pkg::LEN_1;
      sdr_pkg::BL_2: burst_len = sdr_pkg::LEN_2;
      sdr_pkg::BL_4: burst_len = sdr_pkg::LEN_4;
      sdr_pkg::BL_8: burst_len = sdr_pkg::LEN_8;
      sdr_pkg::BL_PAGE: burst_len = sdr_pkg::LEN_PAGE;
      default: burst_len = sdr_pkg::LEN_1;
    endcase
  endfunction

  function automatic logic [7:0] burst_col(input logic [7:0] start,
      input logic [7:0] idx, input logic [8:0] len, input logic ilv);
    logic [7:0] mask;
    mask = 8'(len - sdr_pkg::LEN_1);
    if (ilv) begin
      burst_col = (start & ~mask) | ((start ^ idx) & mask);
    end else begin
      burst_col = (start & ~mask) | (8'(start + idx) & mask);
    end
  endfunction

  assign cmd = decode({cs_n, ras_n, cas_n, we_n});
  assign bank = {bank_select_high, bank_select_low};
  assign blen = burst_len(st.mode[sdr_pkg::BL_MSB:sdr_pkg::BL_LSB]);
  assign full_page = st.mode[sdr_pkg::BL_MSB:sdr_pkg::BL_LSB]
      == sdr_pkg::BL_PAGE;
  assign order = st.mode[sdr_pkg::ORDER_BIT] && !full_page;
  // reserved latency codes behave as three
  assign lat3 = st.mode[sdr_pkg::LAT_MSB:sdr_pkg::LAT_LSB] != sdr_pkg::LAT_2;
  assign new_len = (cmd == sdr_pkg::CMD_WRITE && st.mode[sdr_pkg::WBM_BIT])
      ? sdr_pkg::LEN_1 : blen;
  assign pre_hit = st.bst != sdr_pkg::BST_IDLE
      && (addr[sdr_pkg::AP_BIT] || bank == st.bst_bank);

  always_comb begin
    nx = st;
    iss_valid = 1'b0;
    iss_wr = 1'b0;
    iss_addr = '0;
    rd_en = 1'b0;
    rd_addr = '0;
    // gate sampled here acts one cycle later
    nx.cke_q = cke;
    nx.dqm_q = dqm;
    // suspended cycles freeze all burst state
    if (st.cke_q) begin
      if (st.bst != sdr_pkg::BST_IDLE) begin
        iss_valid = 1'b1;
        iss_wr = st.bst == sdr_pkg::BST_WRITE;
        iss_addr = {st.bst_bank, st.open_row[st.bst_bank],
            burst_col(st.bst_start, st.bst_idx, blen, order)};
        nx.bst_idx = st.bst_idx + 8'h01;
        nx.bst_left = st.bst_left - sdr_pkg::LEN_1;
        if (st.bst_left == sdr_pkg::LEN_1 && !full_page) begin
          nx.bst = sdr_pkg::BST_IDLE;
          if (st.bst_ap) begin
            nx.bank_open[st.bst_bank] = 1'b0;
          end
        end
      end
      case (cmd)
        sdr_pkg::CMD_ACTIVE: begin
          nx.bank_open[bank] = 1'b1;
          nx.open_row[bank] = addr;
        end
        // new column command overrides any burst
        sdr_pkg::CMD_READ, sdr_pkg::CMD_WRITE: begin
          iss_valid = 1'b1;
          iss_wr = cmd == sdr_pkg::CMD_WRITE;
          // bank, row and column form the cell address
          iss_addr = {bank, st.open_row[bank], addr[sdr_pkg::COL_W-1:0]};
          nx.bst = iss_wr ? sdr_pkg::BST_WRITE : sdr_pkg::BST_READ;
          nx.bst_bank = bank;
          nx.bst_start = addr[sdr_pkg::COL_W-1:0];
          nx.bst_idx = 8'h01;
          nx.bst_left = new_len - sdr_pkg::LEN_1;
          nx.bst_ap = addr[sdr_pkg::AP_BIT] && !full_page;
          if (new_len == sdr_pkg::LEN_1) begin
            nx.bst = sdr_pkg::BST_IDLE;
            if (addr[sdr_pkg::AP_BIT]) begin
              nx.bank_open[bank] = 1'b0;
            end
          end
        end
        sdr_pkg::CMD_TERMINATE: begin
          iss_valid = 1'b0;
          nx.bst = sdr_pkg::BST_IDLE;
        end
        sdr_pkg::CMD_PRECHARGE: begin
          if (addr[sdr_pkg::AP_BIT]) begin
            nx.bank_open = '0;
          end else begin
            nx.bank_open[bank] = 1'b0;
          end
          // cut the burst so output floats after latency
          if (pre_hit) begin
            iss_valid = 1'b0;
            nx.bst = sdr_pkg::BST_IDLE;
          end
        end
        // mode load only with all banks idle
        sdr_pkg::CMD_LOAD_MODE: begin
          if (st.bank_open == '0 && st.mode[sdr_pkg::OPM_MSB:sdr_pkg::OPM_LSB]
              == sdr_pkg::OPM_NORMAL && addr[sdr_pkg::OPM_MSB:sdr_pkg::OPM_LSB]
              == sdr_pkg::OPM_NORMAL) begin
            nx.mode = addr;
          end
        end
        default: begin
        end
      endcase
      nx.stg_valid = {st.stg_valid[0], iss_valid && !iss_wr};
      nx.stg_addr = {st.stg_addr[0], iss_addr};
      // stage picked by latency lands data at n+m
      rd_en = lat3 ? st.stg_valid[1] : st.stg_valid[0];
      rd_addr = lat3 ? st.stg_addr[1] : st.stg_addr[0];
      // mask seen two edges before the data word
      nx.oe_n = rd_en ? st.dqm_q : sdr_pkg::MASK_ALL;
      // Write floats the bus and drops reads in flight
      if (cmd == sdr_pkg::CMD_WRITE) begin
        nx.stg_valid = '0;
        nx.oe_n = sdr_pkg::MASK_ALL;
        rd_en = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '0;
      st.mode <= sdr_pkg::MODE_RESET;
      st.cke_q <= 1'b1;
      st.dqm_q <= sdr_pkg::MASK_ALL;
      st.oe_n <= sdr_pkg::MASK_ALL;
    end else begin
      st <= nx;
    end
  end

  assign dq_oe_n = st.oe_n;

  // mask and data from the same edge; no write delay
  sdr_cell_array #(
    .ADDR_W(sdr_pkg::ADDR_W),
    .DATA_W(sdr_pkg::DATA_W)
  ) u_sdr_cell_array (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(iss_valid && iss_wr),
    .wr_addr(iss_addr),
    .wr_data(dq_in),
    .wr_be(~dqm),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(dq_out)
  );

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_col;
    st.cke_q && (cmd == sdr_pkg::CMD_READ || cmd == sdr_pkg::CMD_WRITE);
  endsequence
  sequence s_wr;
    st.cke_q && cmd == sdr_pkg::CMD_WRITE;
  endsequence
  sequence s_quiet;
    st.cke_q && cmd != sdr_pkg::CMD_READ && cmd != sdr_pkg::CMD_WRITE
        && cmd != sdr_pkg::CMD_LOAD_MODE;
  endsequence
  sequence s_live;
    s_quiet ##0 dqm == sdr_pkg::MASK_NONE;
  endsequence
  sequence s_pre_cut;
    st.cke_q && cmd == sdr_pkg::CMD_PRECHARGE && pre_hit;
  endsequence
  sequence s_rd_go;
    st.cke_q && cmd == sdr_pkg::CMD_READ && dqm == sdr_pkg::MASK_NONE;
  endsequence
  sequence s_step;
    st.cke_q && st.bst != sdr_pkg::BST_IDLE
        && (cmd == sdr_pkg::CMD_NOP || cmd == sdr_pkg::CMD_INHIBIT);
  endsequence

  a_col_every_cycle: assert property (
    s_col |-> iss_valid && iss_addr[7:0] == addr[7:0])
    else $error("Column command not taken");
  a_suspend_entry: assert property (
    !cke |=> !(iss_valid && iss_wr) && !rd_en && $stable(st.bst_idx))
    else $error("Activity in suspended cycle");
  a_suspend_exit: assert property (
    (cke ##1 cmd == sdr_pkg::CMD_WRITE) |-> iss_valid && iss_wr)
    else $error("Write lost after resume");
  a_write_mask: assert property (
    s_wr |-> iss_valid && iss_wr && ~dqm == u_sdr_cell_array.wr_be)
    else $error("Write mask not same edge");
  a_write_first: assert property (
    s_wr |-> u_sdr_cell_array.wr_data == dq_in && iss_addr[7:0] == addr[7:0])
    else $error("First write word not taken");
  a_read_mask: assert property (
    dqm == sdr_pkg::MASK_ALL ##1 st.cke_q |=> dq_oe_n == sdr_pkg::MASK_ALL)
    else $error("Read mask did not float output");
  a_pre_float_lat3: assert property (
    (s_pre_cut ##0 lat3) ##1 s_quiet[*2] |=> dq_oe_n == sdr_pkg::MASK_ALL)
    else $error("Output driven after precharge, latency 3");
  a_pre_float_lat2: assert property (
    (s_pre_cut ##0 !lat3) ##1 s_quiet |=> dq_oe_n == sdr_pkg::MASK_ALL)
    else $error("Output driven after precharge, latency 2");
  a_read_lat2: assert property (
    (s_rd_go ##0 !lat3) ##1 s_quiet |=> dq_oe_n == sdr_pkg::MASK_NONE)
    else $error("Read data not driven at latency 2");
  a_read_lat3: assert property (
    (s_rd_go ##0 lat3) ##1 s_live ##1 s_quiet
        |=> dq_oe_n == sdr_pkg::MASK_NONE)
    else $error("Read data not driven at latency 3");
  a_mode_busy: assert property (
    st.cke_q && cmd == sdr_pkg::CMD_LOAD_MODE && st.bank_open != '0
        |=> $stable(st.mode))
    else $error("Mode loaded with a bank open");
  a_single_write: assert property (
    s_wr ##0 st.mode[sdr_pkg::WBM_BIT] |=> st.bst == sdr_pkg::BST_IDLE)
    else $error("Write burst despite single-write mode");
  a_block_wrap: assert property (
    s_step ##0 !full_page |-> (iss_addr[7:0] & ~8'(blen - 9'h001))
        == (st.bst_start & ~8'(blen - 9'h001)))
    else $error("Burst left its block");
  a_ilv_order: assert property (
    s_step ##0 order |-> ((iss_addr[7:0] ^ st.bst_start)
        & 8'(blen - 9'h001)) == (st.bst_idx & 8'(blen - 9'h001)))
    else $error("Interleaved order wrong");
  a_activate_row: assert property (
    st.cke_q && cmd == sdr_pkg::CMD_ACTIVE
        |=> st.open_row[$past(bank)] == $past(addr) && st.bank_open[$past(bank)])
    else $error("Activate did not open row");
endmodule
`default_nettype wire

/* File: sim/sdr_host.sv */
// Controller model: drives commands, masks and write data
`timescale 1ns/100ps
`default_nettype none
module sdr_host #(
  parameter int INIT_NOPS = 10000
) (
  input wire logic clk_sys,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic bank_select_low,
  output logic bank_select_high,
  output logic [11:0] addr,
  output logic [1:0] dqm,
  output logic [15:0] dq_in
);
  int t = 0;
  int last_wr = -9;
  int last_lm = -9;
  initial begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = sdr_pkg::CMD_NOP;
    {bank_select_high, bank_select_low, addr} = 14'h0000;
    dqm = 2'h3;
    dq_in = 16'h0000;
  end
  task automatic drive(input logic [3:0] c, input logic [13:0] ba,
      input logic [15:0] d, input logic [1:0] m, input bit wd);
    @(negedge clk_sys);
    {cs_n, ras_n, cas_n, we_n} = c;
    {bank_select_high, bank_select_low, addr} = ba;
    dqm = m;
    // Released bus flips so stale data never looks valid
    dq_in = wd ? d : ~dq_in;
    if (wd)
      last_wr = t;
    if (c == sdr_pkg::CMD_LOAD_MODE)
      last_lm = t;
    t++;
  endtask
  task automatic issue(input logic [3:0] c, input logic [13:0] ba,
      input logic [15:0] d = 16'h0000, input logic [1:0] m = 2'h0,
      input bit wd = 1'b0);
    int n;
    n = last_lm + 2 - t;
    if (c == sdr_pkg::CMD_ACTIVE || c == sdr_pkg::CMD_REFRESH)
      n = (last_wr + 6 - t > n) ? last_wr + 6 - t : n;
    if (c == sdr_pkg::CMD_PRECHARGE && last_wr + 3 - t > n)
      n = last_wr + 3 - t;
    // next edge after data is free
    repeat (n > 0 ? n : 0) drive(sdr_pkg::CMD_NOP, ba, 16'h0000, 2'h0, 1'b0);
    drive(c, ba, d, m, wd);
  endtask
  // first gated edge still taken; reads after it must vanish
  task automatic pause(input int n);
    for (int i = 0; i <= n; i++) begin
      @(negedge clk_sys);
      cke = i == n;
      {cs_n, ras_n, cas_n, we_n} = i ? sdr_pkg::CMD_READ : sdr_pkg::CMD_NOP;
      dqm = 2'h0;
      t++;
    end
  endtask
  task automatic load(input logic [11:0] mode);
    issue(sdr_pkg::CMD_PRECHARGE, 14'h0400);
    issue(sdr_pkg::CMD_LOAD_MODE, {2'h0, mode});
  endtask
  task automatic init(input logic [11:0] mode);
    // idle only, mask and gate high
    repeat (INIT_NOPS)
      drive(sdr_pkg::CMD_NOP, 14'h0000, 16'h0000, 2'h3, 1'b0);
    issue(sdr_pkg::CMD_PRECHARGE, 14'h0400);
    repeat (2) issue(sdr_pkg::CMD_REFRESH, 14'h0000);
    load(mode);
  endtask
endmodule
`default_nettype wire

/* File: sim/sdr_cmd_timing_burst_test.sv */
// Self-checking bench for the synchronous DRAM device
`timescale 1ns/100ps
`default_nettype none
module sdr_cmd_timing_burst_test;
  typedef struct {
    int edge_no;
    logic [1:0] oe_n;
    logic [17:0] word;
  } note_type;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cke, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high;
  logic [11:0] addr, row;
  logic [1:0] dqm, dq_oe_n, b;
  logic [15:0] dq_in, dq_out;
  logic [7:0] s;
  int seed = 32'h7c88;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  int len, lat;
  bit ilv, wbm, pg;
  logic [17:0] mem [int];
  note_type notes [$];
  always #5 clk_sys = ~clk_sys;
  sdr_device u_sdr_device (.clk_sys(clk_sys), .rst(rst), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_select_low(bank_select_low), .bank_select_high(bank_select_high),
    .addr(addr), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n));
  sdr_host u_sdr_host (.clk_sys(clk_sys), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_select_low(bank_select_low), .bank_select_high(bank_select_high),
    .addr(addr), .dqm(dqm), .dq_in(dq_in));
  task automatic miss(input string msg);
    mismatches++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [7:0] col_of(input logic [7:0] st, input int i);
    logic [7:0] lo;
    lo = ilv ? st ^ 8'(i) : st + 8'(i);
    return 8'((st & ~(len - 1)) | (lo & (len - 1)));
  endfunction
  task automatic check_word(input note_type nt);
    logic [15:0] k;
    comparisons++;
    // Unwritten or floated bytes carry no value to compare
    k = {{8{nt.word[17] & !nt.oe_n[1]}}, {8{nt.word[16] & !nt.oe_n[0]}}};
    if (cyc != nt.edge_no || dq_oe_n !== nt.oe_n
        || (dq_out & k) !== (nt.word[15:0] & k))
      miss("read word wrong");
  endtask
  task automatic setmode(input logic [2:0] blc, input bit o,
      input logic [2:0] lc, input bit w, input logic [1:0] opm);
    u_sdr_host.load({2'h0, w, opm, lc, o, blc});
    if (opm == sdr_pkg::OPM_NORMAL) begin
      len = (blc == sdr_pkg::BL_PAGE) ? 256 : 1 << blc;
      lat = (lc == sdr_pkg::LAT_2) ? 2 : 3;
      ilv = o;
      wbm = w;
    end
  endtask
  task automatic idle;
    repeat (8) u_sdr_host.issue(sdr_pkg::CMD_NOP, 14'h0000);
  endtask
  task automatic wr(input int n, input logic [3:0] fin);
    logic [15:0] d;
    logic [1:0] m;
    logic [17:0] o;
    int k;
    for (int i = 0; i < n; i++) begin
      d = 16'($random(seed));
      m = 2'($random(seed));
      k = {b, row, col_of(s, i)};
      o = mem.exists(k) ? mem[k] : 18'h00000;
      if (!m[0])
        o = {o[17], 1'b1, o[15:8], d[7:0]};
      if (!m[1])
        o = {1'b1, o[16], d[15:8], o[7:0]};
      mem[k] = o;
      u_sdr_host.issue(i ? sdr_pkg::CMD_NOP : sdr_pkg::CMD_WRITE,
        {b, 4'h0, s}, d, m, 1'b1);
    end
    if (fin != sdr_pkg::CMD_NOP)
      u_sdr_host.issue(fin, {b, 12'h000});
  endtask
  task automatic rd(input logic [7:0] st, input int n, input logic [1:0] m,
      input logic [3:0] fin);
    note_type nt;
    int e, k;
    u_sdr_host.issue(sdr_pkg::CMD_READ, {b, 4'h0, st}, 16'h0000, m);
    e = cyc + 1;
    for (int i = 0; i < n; i++) begin
      k = {b, row, col_of(st, i)};
      nt.edge_no = e + lat + i;
      nt.oe_n = (lat + i == 2) ? m : 2'h0;
      nt.word = mem.exists(k) ? mem[k] : 18'h00000;
      if (nt.oe_n != 2'h3)
        notes.push_back(nt);
    end
    repeat (n - 1) u_sdr_host.issue(sdr_pkg::CMD_NOP, 14'h0000);
    if (fin != sdr_pkg::CMD_NOP)
      u_sdr_host.issue(fin, {b, 12'h000});
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    while (notes.size() > 0 && notes[0].edge_no < cyc) begin
      void'(notes.pop_front());
      miss("read word missing");
    end
    if (!rst && dq_oe_n !== 2'h3) begin
      if (notes.size() == 0)
        miss("output not expected");
      else
        check_word(notes.pop_front());
    end
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    miss("run did not finish");
    wrap_up();
  end
  initial begin
    logic [2:0] lc;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    u_sdr_host.init(12'h020);
    for (int j = 0; j < 18; j++) begin
      lc = (j[3] || j == 17) ? sdr_pkg::LAT_3 : sdr_pkg::LAT_2;
      pg = j > 15;
      setmode(pg ? sdr_pkg::BL_PAGE : 3'(j % 4), !pg && j[2], lc,
        j % 5 == 4, sdr_pkg::OPM_NORMAL);
      b = 2'($random(seed));
      row = 12'($random(seed));
      s = pg ? 8'hFA : 8'($random(seed));
      u_sdr_host.issue(sdr_pkg::CMD_ACTIVE, {b, row});
      wr(wbm ? 1 : (pg ? 10 : len),
        pg ? sdr_pkg::CMD_TERMINATE : sdr_pkg::CMD_NOP);
      rd(pg ? s : col_of(s, $random(seed)), pg ? 10 : (len == 8 ? 3 : len),
        2'($random(seed)), pg ? sdr_pkg::CMD_TERMINATE :
        (len == 8 ? sdr_pkg::CMD_PRECHARGE : sdr_pkg::CMD_NOP));
      idle();
    end
    setmode(sdr_pkg::BL_4, 1'b0, sdr_pkg::LAT_2, 1'b0, sdr_pkg::OPM_NORMAL);
    u_sdr_host.issue(sdr_pkg::CMD_ACTIVE, {b, row});
    u_sdr_host.issue(sdr_pkg::CMD_LOAD_MODE, {2'h0, 12'h037});
    s = 8'h10;
    wr(4, sdr_pkg::CMD_NOP);
    rd(8'h11, 1, 2'h0, sdr_pkg::CMD_NOP);
    rd(8'h12, 4, 2'h0, sdr_pkg::CMD_NOP);
    idle();
    u_sdr_host.pause(3);
    idle();
    setmode(sdr_pkg::BL_1, 1'b0, sdr_pkg::LAT_3, 1'b0, 2'h1);
    rd(8'h13, 4, 2'h0, sdr_pkg::CMD_NOP);
    idle();
    comparisons++;
    if (notes.size() != 0)
      miss("reads left over");
    wrap_up();
  end
endmodule
`default_nettype wire
